// ---- verilog/iepc_pkg.sv ----
/*
  Constants and types of the interrupt enable and priority controller.
  Assumes a single clock domain and an AXI4-Lite register port whose byte
  address is four times the register index.
*/
package iepc_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0] IEPC_IDX_EN_BASE = 8'ha8;
  localparam logic [7:0] IEPC_IDX_EN_EXT = 8'ha9;
  localparam logic [7:0] IEPC_IDX_PRIO_LO_A = 8'hb8;
  localparam logic [7:0] IEPC_IDX_PRIO_HI_A = 8'hb9;
  localparam logic [7:0] IEPC_IDX_PRIO_LO_B = 8'hba;
  localparam logic [7:0] IEPC_IDX_PRIO_HI_B = 8'hbb;
  localparam logic [7:0] IEPC_IDX_STATUS = 8'hc0;
  localparam logic [7:0] IEPC_IDX_MASK = 8'hc1;

  // Field positions
  localparam int IEPC_GLOBAL_EN_BIT = 7;
  localparam int IEPC_ST_TAKEN_BIT = 0;
  localparam int IEPC_ST_PREEMPT_BIT = 1;
  localparam int IEPC_ST_WAKE_BIT = 2;

  // Reset values
  localparam logic [5:0] IEPC_RST_BANK = 6'h00;
  localparam logic [2:0] IEPC_RST_EVT = 3'h0;

  // Source numbering: bank a bits 5..0 are ids 5..0, bank b ids 11..6
  localparam int IEPC_NUM_SRC = 12;
  localparam logic [3:0] IEPC_SRC_EXT_PIN_C = 4'h8;

  // AXI responses
  localparam logic [1:0] IEPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEPC_RESP_SLVERR = 2'h2;

  typedef logic [1:0] iepc_lvl_t;

  typedef struct packed {
    logic valid;
    logic [3:0] id;
    iepc_lvl_t level;
  } iepc_irq_req_t;

endpackage : iepc_pkg

// ---- verilog/iepc_ctrl.sv ----
/*
  Interrupt enable and four-level priority controller with AXI4-Lite
  register port. Assumes source flags, ack and done arrive from logic on
  aclk, and that the core acknowledges only a request that is presented.
*/
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Level is high bit over low bit
// R2 - Pairs 10,01,00 give levels 2,1,0; reset 00
// R3 - Timer2 priority from bank a bit 5
// R4 - First serial port from bank a bit 4
// R5 - Timer1 priority from bank a bit 3
// R6 - External pin b from bank a bit 2
// R7 - Timer0 priority from bank a bit 1
// R8 - External pin a from bank a bit 0
// R9 - Second serial port from bank b bit 5
// R10 - SPI priority from bank b bit 4
// R11 - ADC/touch priority from bank b bit 3
// R12 - External pin c from bank b bit 2
// R13 - Pin-change priority from bank b bit 1
// R14 - Timer3 priority from bank b bit 0
// R15 - Extended enables bits 5..0, reset zero
// R16 - Pin c wakes ignoring global; pin-change wake ungated
// R17 - Global enable off blocks all requests
// R18 - Not-higher level waits for current handler
// R19 - Higher level preempts; preempted handler resumes
module iepc_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Sources
  input wire logic [11:0] src_pend,
  input wire logic [1:0] ext_pin_ab_level,
  input wire logic pin_change_wake_req,
  // Core
  output iepc_pkg::iepc_irq_req_t irq_req,
  input wire logic irq_ack,
  input wire logic irq_done,
  output logic wake_core,
  output logic irq_out
);
  import iepc_pkg::*;

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == IEPC_IDX_EN_BASE) || (idx == IEPC_IDX_EN_EXT) ||
      (idx == IEPC_IDX_PRIO_LO_A) || (idx == IEPC_IDX_PRIO_HI_A) ||
      (idx == IEPC_IDX_PRIO_LO_B) || (idx == IEPC_IDX_PRIO_HI_B) ||
      (idx == IEPC_IDX_STATUS) || (idx == IEPC_IDX_MASK);
  endfunction : is_mapped

  // Highest set in-service level
  function automatic iepc_lvl_t top_level(input logic [3:0] svc);
    top_level = svc[3] ? 2'h3 : svc[2] ? 2'h2 : svc[1] ? 2'h1 : 2'h0;
  endfunction : top_level

  // Highest level wins; equal levels go to the lowest id
  function automatic logic [6:0] pick(input logic [11:0] pend,
    input logic [11:0] hi, input logic [11:0] lo);
    logic found;
    logic [3:0] id;
    iepc_lvl_t best;
    found = 1'b0;
    id = 4'h0;
    best = 2'h0;
    for (int i = IEPC_NUM_SRC - 1; i >= 0; i--)
    begin
      if (pend[i] && (!found || {hi[i], lo[i]} >= best))
      begin
        found = 1'b1;
        id = 4'(i);
        best = {hi[i], lo[i]};
      end
    end
    pick = {found, id, best};
  endfunction : pick

  // Register state
  logic global_en_q;
  logic [5:0] en_base_q;
  logic [5:0] en_ext_q;
  logic [5:0] prio_lo_a_q;
  logic [5:0] prio_hi_a_q;
  logic [5:0] prio_lo_b_q;
  logic [5:0] prio_hi_b_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;

  // Bus state
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] wr_idx_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Core state
  logic [3:0] in_svc_q;
  iepc_irq_req_t irq_q;
  logic wake_q;
  logic irq_out_q;

  // Bus decode
  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire b_hs = bvalid_q & bready;
  wire ar_hs = arvalid & arready_q;
  wire r_hs = rvalid_q & rready;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_en = wr_go & wstrb0_q;
  wire [7:0] rd_idx = araddr[9:2];
  wire [7:0] wdata_b = wdata_q[7:0];
  wire wr_base = wr_en && (wr_idx_q == IEPC_IDX_EN_BASE);
  wire wr_ext = wr_en && (wr_idx_q == IEPC_IDX_EN_EXT);
  wire wr_lo_a = wr_en && (wr_idx_q == IEPC_IDX_PRIO_LO_A);
  wire wr_hi_a = wr_en && (wr_idx_q == IEPC_IDX_PRIO_HI_A);
  wire wr_lo_b = wr_en && (wr_idx_q == IEPC_IDX_PRIO_LO_B);
  wire wr_hi_b = wr_en && (wr_idx_q == IEPC_IDX_PRIO_HI_B);
  wire wr_stat = wr_en && (wr_idx_q == IEPC_IDX_STATUS);
  wire wr_mask = wr_en && (wr_idx_q == IEPC_IDX_MASK);

  wire [7:0] rd_byte =
    (rd_idx == IEPC_IDX_EN_BASE) ? {global_en_q, 1'b0, en_base_q} :
    (rd_idx == IEPC_IDX_EN_EXT) ? {2'h0, en_ext_q} :
    (rd_idx == IEPC_IDX_PRIO_LO_A) ? {2'h0, prio_lo_a_q} :
    (rd_idx == IEPC_IDX_PRIO_HI_A) ? {2'h0, prio_hi_a_q} :
    (rd_idx == IEPC_IDX_PRIO_LO_B) ? {2'h0, prio_lo_b_q} :
    (rd_idx == IEPC_IDX_PRIO_HI_B) ? {2'h0, prio_hi_b_q} :
    (rd_idx == IEPC_IDX_STATUS) ? {5'h00, status_q} :
    (rd_idx == IEPC_IDX_MASK) ? {5'h00, mask_q} : 8'h00;

  // Per-source views, ids 5..0 from bank a and 11..6 from bank b
  wire [11:0] prio_hi_vec = {prio_hi_b_q, prio_hi_a_q}; // R3 R4 R5 R6 R7 R8
  wire [11:0] prio_lo_vec = {prio_lo_b_q, prio_lo_a_q}; // R9 R10 R11 R12 R13 R14
  wire [11:0] en_vec = {en_ext_q, en_base_q}; // R15

  // Candidate selection
  wire [11:0] pend_en = src_pend & en_vec & {12{global_en_q}}; // R17
  wire [6:0] cand = pick(pend_en, prio_hi_vec, prio_lo_vec); // R1 R2
  wire cand_found = cand[6];
  wire [3:0] cand_id = cand[5:2];
  wire [1:0] cand_lvl = cand[1:0];
  wire in_any = |in_svc_q;
  wire [1:0] cur_lvl = top_level(in_svc_q);
  wire cand_ok = cand_found && (!in_any || cand_lvl > cur_lvl); // R18 R19

  // In-service stack of levels
  wire ack_ok = irq_ack & irq_q.valid;
  wire [3:0] top_bit = in_any ? (4'h1 << cur_lvl) : 4'h0;
  wire [3:0] svc_after_done = irq_done ? (in_svc_q & ~top_bit) : in_svc_q;
  wire [3:0] in_svc_d = ack_ok ?
    (svc_after_done | (4'h1 << irq_q.level)) : svc_after_done; // R19

  iepc_irq_req_t irq_d;
  assign irq_d.valid = cand_ok & ~ack_ok;
  assign irq_d.id = cand_id;
  assign irq_d.level = cand_lvl;

  // Wake-up: pin enables only, no global gate
  wire wake_d = (en_base_q[0] & ext_pin_ab_level[0]) |
    (en_base_q[2] & ext_pin_ab_level[1]) |
    (en_ext_q[2] & src_pend[IEPC_SRC_EXT_PIN_C]) |
    pin_change_wake_req; // R16

  // Sticky events, set wins over write-one-clear
  wire [2:0] evt_set = {wake_d & ~wake_q, ack_ok & in_any, ack_ok & ~in_any};
  wire [2:0] evt_clr = wr_stat ? wdata_b[2:0] : 3'h0;
  wire [2:0] status_d = (status_q & ~evt_clr) | evt_set;

  // Write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= IEPC_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
        wr_idx_q <= awaddr[9:2];
      end
      if (w_hs)
      begin
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
        wdata_q <= wdata;
        wstrb0_q <= wstrb[0];
      end
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(wr_idx_q) ? IEPC_RESP_OKAY : IEPC_RESP_SLVERR;
      end
      if (b_hs)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= IEPC_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= is_mapped(rd_idx) ? IEPC_RESP_OKAY : IEPC_RESP_SLVERR;
    end
    else if (r_hs)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      global_en_q <= 1'b0;
      en_base_q <= IEPC_RST_BANK;
      en_ext_q <= IEPC_RST_BANK; // R15
      prio_lo_a_q <= IEPC_RST_BANK; // R2
      prio_hi_a_q <= IEPC_RST_BANK;
      prio_lo_b_q <= IEPC_RST_BANK;
      prio_hi_b_q <= IEPC_RST_BANK;
      mask_q <= IEPC_RST_EVT;
    end
    else
    begin
      if (wr_base)
      begin
        global_en_q <= wdata_b[IEPC_GLOBAL_EN_BIT];
        en_base_q <= wdata_b[5:0];
      end
      if (wr_ext)
        en_ext_q <= wdata_b[5:0]; // R15
      if (wr_lo_a)
        prio_lo_a_q <= wdata_b[5:0];
      if (wr_hi_a)
        prio_hi_a_q <= wdata_b[5:0];
      if (wr_lo_b)
        prio_lo_b_q <= wdata_b[5:0];
      if (wr_hi_b)
        prio_hi_b_q <= wdata_b[5:0];
      if (wr_mask)
        mask_q <= wdata_b[2:0];
    end
  end

  // Core-facing state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_svc_q <= 4'h0;
      irq_q <= '0;
      wake_q <= 1'b0;
      status_q <= IEPC_RST_EVT;
      irq_out_q <= 1'b0;
    end
    else
    begin
      in_svc_q <= in_svc_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
      status_q <= status_d;
      irq_out_q <= |(status_d & mask_q);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign irq_req = irq_q;
  assign wake_core = wake_q;
  assign irq_out = irq_out_q;

  property p_level_pair;
    @(posedge aclk) disable iff (!aresetn)
    irq_q.valid && $stable(prio_hi_vec) && $stable(prio_lo_vec) |->
      irq_q.level == {prio_hi_vec[irq_q.id], prio_lo_vec[irq_q.id]};
  endproperty
  a_level_pair: assert property (p_level_pair) // R1
    else $error("presented level differs from priority pair");

  property p_reset_prio;
    @(posedge aclk)
    !aresetn |=> (prio_hi_vec == 12'h000) && (prio_lo_vec == 12'h000);
  endproperty
  a_reset_prio: assert property (p_reset_prio) // R2
    else $error("priority pairs not zero after reset");

  property p_timer_two_pair;
    @(posedge aclk) disable iff (!aresetn)
    irq_q.valid && irq_q.id == 4'h5 && $stable(prio_hi_a_q) &&
      $stable(prio_lo_a_q) |-> irq_q.level == {prio_hi_a_q[5], prio_lo_a_q[5]};
  endproperty
  a_timer_two_pair: assert property (p_timer_two_pair) // R3
    else $error("timer two level not from bank a bit 5");

  property p_serial_b_pair;
    @(posedge aclk) disable iff (!aresetn)
    irq_q.valid && irq_q.id == 4'hb && $stable(prio_hi_b_q) &&
      $stable(prio_lo_b_q) |-> irq_q.level == {prio_hi_b_q[5], prio_lo_b_q[5]};
  endproperty
  a_serial_b_pair: assert property (p_serial_b_pair) // R9
    else $error("second serial level not from bank b bit 5");

  property p_enable_gate;
    @(posedge aclk) disable iff (!aresetn)
    irq_q.valid && $stable(en_vec) |-> en_vec[irq_q.id];
  endproperty
  a_enable_gate: assert property (p_enable_gate) // R15
    else $error("request presented for a disabled source");

  property p_pin_c_wake;
    @(posedge aclk) disable iff (!aresetn)
    en_ext_q[2] && src_pend[IEPC_SRC_EXT_PIN_C] |=> wake_q;
  endproperty
  a_pin_c_wake: assert property (p_pin_c_wake) // R16
    else $error("pin c did not wake the core");

  property p_global_block;
    @(posedge aclk) disable iff (!aresetn)
    !$past(global_en_q) |-> !irq_q.valid;
  endproperty
  a_global_block: assert property (p_global_block) // R17
    else $error("request presented with global enable off");

  property p_wait_lower;
    @(posedge aclk) disable iff (!aresetn)
    irq_q.valid && $past(in_any) |-> irq_q.level > $past(cur_lvl);
  endproperty
  a_wait_lower: assert property (p_wait_lower) // R18
    else $error("request not above the level in service");

  property p_preempt_nest;
    @(posedge aclk) disable iff (!aresetn)
    ack_ok && in_any && !irq_done |=>
      in_svc_q == ($past(in_svc_q) | (4'h1 << $past(irq_q.level))) ##1
      in_svc_q != 4'h0;
  endproperty
  a_preempt_nest: assert property (p_preempt_nest) // R19
    else $error("preemption lost the interrupted level");

  property p_irq_out;
    @(posedge aclk) disable iff (!aresetn)
    |(status_q & mask_q) && !wr_stat |-> ##[0:1] irq_out_q;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("unmasked event did not raise the interrupt");

endmodule : iepc_ctrl

// ---- dv/iepc_core_model.sv ----
/*
  Behavioural core that takes requests of the controller.
  Assumes the bench clears serviced source flags and commands returns.
*/
`timescale 1ns/1ps
module iepc_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire iepc_pkg::iepc_irq_req_t irq_req,
  output logic irq_ack,
  output logic irq_done,
  // Bench side
  input wire logic [3:0] ack_wait,
  input wire logic done_cmd,
  output logic [3:0] taken_id,
  output logic [1:0] taken_lvl,
  output logic [7:0] takes
);
  import iepc_pkg::*;
  logic [3:0] wait_q;
  // Acks only a presented request, after ack_wait cycles of it
  always_ff @(posedge aclk)
  begin
    irq_done <= done_cmd & aresetn;
    if (!aresetn)
      takes <= 8'h00;
    if (!aresetn || !irq_req.valid || irq_ack)
    begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (wait_q == ack_wait)
    begin
      irq_ack <= 1'b1;
      taken_id <= irq_req.id;
      taken_lvl <= irq_req.level;
      takes <= takes + 8'h01;
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule : iepc_core_model

// ---- dv/iepc_tb_top.sv ----
/*
  Self-checking bench of the interrupt enable and priority controller.
  Assumes the design, its package and the core model compile first.
*/
`timescale 1ns/1ps
module irq_enable_priority_ctrl_tb_top;
  import iepc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000, src_pend = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0, ack_wait = 4'h0, taken_id;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, pcw = 1'b0, done_cmd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic irq_ack, irq_done, wake_core, irq_out;
  logic [1:0] bresp, rresp, rs, taken_lvl, pin_ab = 2'h0;
  logic [7:0] takes, tk, v;
  logic [1:0] lvl_s [12];
  iepc_irq_req_t irq_req;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] idx_l [8] = '{IEPC_IDX_EN_BASE, IEPC_IDX_EN_EXT,
    IEPC_IDX_PRIO_LO_A, IEPC_IDX_PRIO_HI_A, IEPC_IDX_PRIO_LO_B,
    IEPC_IDX_PRIO_HI_B, IEPC_IDX_STATUS, IEPC_IDX_MASK};

  always #20 aclk = ~aclk;

  iepc_ctrl DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_pend(src_pend),
    .ext_pin_ab_level(pin_ab), .pin_change_wake_req(pcw),
    .irq_req(irq_req), .irq_ack(irq_ack), .irq_done(irq_done),
    .wake_core(wake_core), .irq_out(irq_out)
  );
  iepc_core_model core (
    .aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .irq_ack(irq_ack),
    .irq_done(irq_done), .ack_wait(ack_wait), .done_cmd(done_cmd),
    .taken_id(taken_id), .taken_lvl(taken_lvl), .takes(takes)
  );

  task automatic conclude();
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
  endtask : wr

  task automatic rdr(input logic [7:0] idx);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
  endtask : rdr

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    rdr(idx);
    chk("rdata", rd, {24'h0, exp});
    chk("rresp", 32'(rs), 32'(IEPC_RESP_OKAY));
  endtask : rchk

  // Gathers one bit of six level entries into a priority byte
  function automatic logic [7:0] bank_of(input int base, input int b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 6; i++)
      r[i] = lvl_s[base + i][b];
    return r;
  endfunction : bank_of

  // Spreads the level table over the four priority registers of banks a and b
  task automatic put_prio();
    wr(IEPC_IDX_PRIO_LO_A, bank_of(0, 0));
    wr(IEPC_IDX_PRIO_HI_A, bank_of(0, 1));
    wr(IEPC_IDX_PRIO_LO_B, bank_of(6, 0));
    wr(IEPC_IDX_PRIO_HI_B, bank_of(6, 1));
  endtask : put_prio

  task automatic take(input int id, input logic [1:0] lv);
    tk = takes;
    while (takes == tk) @(posedge aclk);
    chk("taken id", 32'(taken_id), 32'(id));
    chk("taken level", 32'(taken_lvl), 32'(lv));
    src_pend[id] <= 1'b0;
  endtask : take

  task automatic ret();
    done_cmd <= 1'b1;
    @(posedge aclk);
    done_cmd <= 1'b0;
    cyc(3);
  endtask : ret

  task automatic idle_chk(input string nm);
    tk = takes;
    cyc(10);
    chk(nm, 32'(takes), 32'(tk));
  endtask : idle_chk

  initial
  begin
    void'($urandom(32'h46caebbc));
    cyc(2);
    aresetn <= 1'b1;
    foreach (idx_l[i]) rchk(idx_l[i], 8'h00);
    rdr(8'h10);
    chk("unmapped rdata", rd, 32'h0);
    chk("unmapped rresp", 32'(rs), 32'(IEPC_RESP_SLVERR));
    wr(8'h10, 8'hff);
    chk("unmapped bresp", 32'(rs), 32'(IEPC_RESP_SLVERR));
    for (int i = 1; i < 6; i++)
    begin
      v = 8'($urandom()) & 8'h3f;
      wr(idx_l[i], v);
      chk("bresp", 32'(rs), 32'(IEPC_RESP_OKAY));
      rchk(idx_l[i], v);
    end
    // Each source alone, all four level codes met across the loop
    wr(IEPC_IDX_EN_BASE, 8'hbf);
    wr(IEPC_IDX_EN_EXT, 8'h3f);
    v = 8'($urandom());
    for (int id = 0; id < 12; id++)
    begin
      foreach (lvl_s[j]) lvl_s[j] = 2'($urandom());
      lvl_s[id] = 2'(id + int'(v));
      put_prio();
      ack_wait <= 4'($urandom() % 4);
      src_pend[id] <= 1'b1;
      take(id, lvl_s[id]);
      ret();
    end
    chk("irq_out masked", 32'(irq_out), 32'h0);
    wr(IEPC_IDX_MASK, 8'h01);
    cyc(2);
    chk("irq_out", 32'(irq_out), 32'h1);
    wr(IEPC_IDX_STATUS, 8'h01);
    cyc(2);
    chk("irq_out cleared", 32'(irq_out), 32'h0);
    // Global enable off blocks; then own enable still gates
    wr(IEPC_IDX_EN_BASE, 8'h3f);
    src_pend[0] <= 1'b1;
    idle_chk("global off");
    wr(IEPC_IDX_EN_BASE, 8'h81);
    src_pend[2] <= 1'b1;
    take(0, lvl_s[0]);
    ret();
    idle_chk("source disabled");
    src_pend[2] <= 1'b0;
    // Nesting: equal level waits, higher preempts, resumed one holds
    foreach (lvl_s[j]) lvl_s[j] = 2'h0;
    lvl_s[1] = 2'h1;
    lvl_s[3] = 2'h3;
    lvl_s[5] = 2'h1;
    put_prio();
    wr(IEPC_IDX_EN_BASE, 8'hbf);
    wr(IEPC_IDX_STATUS, 8'h07);
    src_pend[1] <= 1'b1;
    take(1, 2'h1);
    src_pend[5] <= 1'b1;
    idle_chk("equal level");
    src_pend[3] <= 1'b1;
    take(3, 2'h3);
    ret();
    idle_chk("resumed level");
    ret();
    take(5, 2'h1);
    ret();
    rchk(IEPC_IDX_STATUS, 8'h03);
    // Pin-change wake ignores every enable
    wr(IEPC_IDX_EN_BASE, 8'h00);
    wr(IEPC_IDX_EN_EXT, 8'h00);
    pcw <= 1'b1;
    cyc(3);
    chk("wake", 32'(wake_core), 32'h1);
    pcw <= 1'b0;
    cyc(3);
    chk("wake off", 32'(wake_core), 32'h0);
    // Pin c and pin b wake with the global enable still off
    wr(IEPC_IDX_EN_EXT, 8'h04);
    src_pend[8] <= 1'b1;
    cyc(3);
    chk("pin c wake", 32'(wake_core), 32'h1);
    src_pend[8] <= 1'b0;
    wr(IEPC_IDX_EN_BASE, 8'h04);
    pin_ab <= 2'h2;
    cyc(3);
    chk("pin b wake", 32'(wake_core), 32'h1);
    pin_ab <= 2'h0;
    cyc(3);
    chk("pin b wake off", 32'(wake_core), 32'h0);
    rchk(IEPC_IDX_STATUS, 8'h07);
    conclude();
  end

  initial
  begin
    #(40 * 20000);
    err_count++;
    conclude();
  end
endmodule : irq_enable_priority_ctrl_tb_top
